// ===== hdl/omp_regs.svh
`ifndef OMP_REGS_SVH
`define OMP_REGS_SVH
`define OMP_IDX_MODE 2'h0
`define OMP_IDX_PULL 2'h1
`define OMP_MOD_HI 7
`define OMP_MOD_LO 5
`define OMP_INTERNAL_VISIBILITY_BIT 3
`define OMP_EMK_BIT 1
`define OMP_EME_BIT 0
`define OMP_PK_BIT 7
`define OMP_PE_BIT 4
`define OMP_PB_BIT 1
`define OMP_PA_BIT 0
`define OMP_M_SSC 3'h0
`define OMP_M_EMN 3'h1
`define OMP_M_STST 3'h2
`define OMP_M_EMW 3'h3
`define OMP_M_NSC 3'h4
`define OMP_M_NXN 3'h5
`define OMP_M_PER 3'h6
`define OMP_M_NXW 3'h7
`define OMP_PULL_RST 4'h0
`define OMP_PE_RST_MASK 8'h60
`define OMP_PE_CTL_MASK 8'h9F
`define OMP_STRAP_CYC 2'h3
`endif

// ===== hdl/omp_pkg.sv
package omp_pkg;
  typedef enum logic [2:0] {
    OMP_ST_INIT = 3'h1,
    OMP_ST_IDLE = 3'h2,
    OMP_ST_ACK = 3'h4
  } omp_state_t;
endpackage

// ===== hdl/omp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "omp_regs.svh"
module omp_ctrl
  import omp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [2:0] mode_strap,
  input wire logic secure_pin,
  input wire logic [7:0] dir_a,
  input wire logic [7:0] dir_b,
  input wire logic [7:0] dir_e,
  input wire logic [7:0] dir_k,
  output logic [2:0] mode_o,
  output logic internal_visibility_o,
  output logic port_k_mapped_o,
  output logic port_e_mapped_o,
  output logic ext_echo_o,
  output logic [7:0] pull_a_o,
  output logic [7:0] pull_b_o,
  output logic [7:0] pull_e_o,
  output logic [7:0] pull_k_o
);

  function automatic logic f_emul(input logic [2:0] m);
    f_emul = (m == `OMP_M_EMN) || (m == `OMP_M_EMW);
  endfunction

  function automatic logic f_special(input logic [2:0] m);
    f_special = (m == `OMP_M_SSC) || (m == `OMP_M_STST) || (m == `OMP_M_PER);
  endfunction

  function automatic logic f_single(input logic [2:0] m);
    f_single = (m == `OMP_M_SSC) || (m == `OMP_M_NSC);
  endfunction

  function automatic logic f_mapped(input logic [2:0] m);
    f_mapped = !m[0] && (m != `OMP_M_PER);
  endfunction

  omp_state_t state_r;
  logic [2:0] strap_s1_r, strap_s2_r, strap_s3_r;
  logic sec_s1_r, sec_s2_r, sec_s3_r, secure_r;
  logic [1:0] cnt_r;
  logic [2:0] mode_r;
  logic internal_visibility_r, emk_r, eme_r;
  logic mod_once_r, internal_visibility_once_r, emk_once_r;
  logic pend_v_r;
  logic [2:0] pend_mode_r;
  logic pend_internal_visibility_r, pend_emk_r, pend_eme_r;
  logic [3:0] pull_r;
  logic wait_r, echo_r;
  logic [31:0] rdata_r;
  logic [7:0] pa_r, pb_r, pe_r, pk_r;
  logic idle_req, ack_wr, in_map, lane0;
  logic [2:0] mod_w, mode_nxt;
  logic mod_ok, internal_visibility_ok, emk_ok, eme_ok;
  logic wr_mode, wr_pull;

  assign idle_req = (state_r == OMP_ST_IDLE) && (read || write);
  assign ack_wr = (state_r == OMP_ST_ACK) && write;
  assign lane0 = byteenable[0];
  assign mod_w = writedata[`OMP_MOD_HI:`OMP_MOD_LO];
  // Registers leave the map in expanded and peripheral modes.
  assign in_map = f_mapped(mode_r);
  assign wr_mode = ack_wr && lane0 && in_map && (address == `OMP_IDX_MODE);
  assign wr_pull = ack_wr && lane0 && in_map && (address == `OMP_IDX_PULL);

  // Strap and secure inputs pass three flops before use.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
      strap_s3_r <= 3'h0;
      sec_s1_r <= 1'h0;
      sec_s2_r <= 1'h0;
      sec_s3_r <= 1'h0;
    end else begin
      strap_s1_r <= mode_strap;
      strap_s2_r <= strap_s1_r;
      strap_s3_r <= strap_s2_r;
      sec_s1_r <= secure_pin;
      sec_s2_r <= sec_s1_r;
      sec_s3_r <= sec_s2_r;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      secure_r <= 1'h0;
    end else if (sec_s2_r == sec_s3_r) begin
      secure_r <= sec_s3_r;
    end
  end

  // Bus handshake: one wait cycle, then one cycle with waitrequest low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= OMP_ST_INIT;
      cnt_r <= 2'h0;
      wait_r <= 1'h1;
    end else begin
      case (state_r)
        OMP_ST_INIT: begin
          if (cnt_r != `OMP_STRAP_CYC) begin
            cnt_r <= cnt_r + 2'h1;
          end else if (strap_s2_r == strap_s3_r) begin
            state_r <= OMP_ST_IDLE;
          end
        end
        OMP_ST_IDLE: begin
          if (read || write) begin
            state_r <= OMP_ST_ACK;
            wait_r <= 1'h0;
          end
        end
        OMP_ST_ACK: begin
          state_r <= OMP_ST_IDLE;
          wait_r <= 1'h1;
        end
        default: begin
          state_r <= OMP_ST_INIT;
          wait_r <= 1'h1;
        end
      endcase
    end
  end

  // Read data and echo flag are captured when a request is taken.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 32'h0;
      echo_r <= 1'h0;
    end else if (idle_req) begin
      rdata_r <= 32'h0;
      echo_r <= !in_map;
      if (in_map && read && address == `OMP_IDX_MODE) begin
        rdata_r[`OMP_MOD_HI:`OMP_MOD_LO] <= mode_r;
        rdata_r[`OMP_INTERNAL_VISIBILITY_BIT] <= internal_visibility_r;
        rdata_r[`OMP_EMK_BIT] <= emk_r;
        rdata_r[`OMP_EME_BIT] <= eme_r;
      end else if (in_map && read && address == `OMP_IDX_PULL) begin
        rdata_r[`OMP_PK_BIT] <= pull_r[3];
        rdata_r[`OMP_PE_BIT] <= pull_r[2];
        rdata_r[`OMP_PB_BIT] <= pull_r[1];
        rdata_r[`OMP_PA_BIT] <= pull_r[0];
      end
    end else begin
      echo_r <= 1'h0;
    end
  end

  // Write permission of each mode register field.
  always_comb begin
    mod_ok = 1'h0;
    mode_nxt = mode_r;
    if (secure_r || mode_r[0]) begin
      mod_ok = 1'h0;
    end else if (!mode_r[2]) begin
      mod_ok = (mod_w != `OMP_M_PER);
      mode_nxt = mod_w;
    end else if (mode_r == `OMP_M_NSC) begin
      mode_nxt = {1'h1, mod_w[1:0]};
      mod_ok = !mod_once_r && mod_w[0];
    end
    internal_visibility_ok = f_special(mode_r) || (!f_emul(mode_r) && !internal_visibility_once_r);
    emk_ok = f_special(mode_r) || (!f_emul(mode_r) && !emk_once_r);
    eme_ok = f_special(mode_r);
  end

  // Accepted fields wait one cycle before they reach the register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_v_r <= 1'h0;
      pend_mode_r <= 3'h0;
      pend_internal_visibility_r <= 1'h0;
      pend_emk_r <= 1'h0;
      pend_eme_r <= 1'h0;
    end else begin
      pend_v_r <= wr_mode;
      if (wr_mode) begin
        pend_mode_r <= mod_ok ? mode_nxt : mode_r;
        pend_internal_visibility_r <= internal_visibility_ok ? writedata[`OMP_INTERNAL_VISIBILITY_BIT] : internal_visibility_r;
        pend_emk_r <= emk_ok ? writedata[`OMP_EMK_BIT] : emk_r;
        pend_eme_r <= eme_ok ? writedata[`OMP_EME_BIT] : eme_r;
      end
    end
  end

  // Mode register: loaded from the strap, then from pending writes.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= `OMP_M_SSC;
      internal_visibility_r <= 1'h0;
      emk_r <= 1'h0;
      eme_r <= 1'h0;
    end else if (state_r == OMP_ST_INIT) begin
      if (cnt_r == `OMP_STRAP_CYC && strap_s2_r == strap_s3_r) begin
        mode_r <= strap_s3_r;
        internal_visibility_r <= f_emul(strap_s3_r) || (strap_s3_r == `OMP_M_STST);
        emk_r <= f_emul(strap_s3_r);
        eme_r <= f_emul(strap_s3_r);
      end
    end else if (pend_v_r) begin
      mode_r <= pend_mode_r;
      internal_visibility_r <= pend_internal_visibility_r;
      emk_r <= pend_emk_r;
      eme_r <= pend_eme_r;
    end
  end

  // Hidden write-once flags, cleared only by reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mod_once_r <= 1'h0;
      internal_visibility_once_r <= 1'h0;
      emk_once_r <= 1'h0;
    end else if (wr_mode) begin
      if (mod_ok && mode_r == `OMP_M_NSC) begin
        mod_once_r <= 1'h1;
      end
      if (internal_visibility_ok && !f_special(mode_r)) begin
        internal_visibility_once_r <= 1'h1;
      end
      if (emk_ok && !f_special(mode_r)) begin
        emk_once_r <= 1'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pull_r <= `OMP_PULL_RST;
    end else if (wr_pull) begin
      pull_r[3] <= writedata[`OMP_PK_BIT];
      pull_r[2] <= writedata[`OMP_PE_BIT];
      pull_r[1] <= writedata[`OMP_PB_BIT];
      pull_r[0] <= writedata[`OMP_PA_BIT];
    end
  end

  // Pulls act per port and only on pins that are inputs, except port E pins 6:5, which are pulled during reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pa_r <= 8'h0;
      pb_r <= 8'h0;
      pk_r <= 8'h0;
      pe_r <= `OMP_PE_RST_MASK;
    end else begin
      pa_r <= pull_r[0] ? ~dir_a : 8'h0;
      pb_r <= pull_r[1] ? ~dir_b : 8'h0;
      pk_r <= pull_r[3] ? ~dir_k : 8'h0;
      pe_r <= pull_r[2] ? (~dir_e & `OMP_PE_CTL_MASK) : 8'h0;
    end
  end

  logic [2:0] mode_q_r;
  logic internal_visibility_q_r, pk_map_r, pe_map_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q_r <= `OMP_M_SSC;
      internal_visibility_q_r <= 1'h0;
      pk_map_r <= 1'h1;
      pe_map_r <= 1'h1;
    end else begin
      mode_q_r <= mode_r;
      internal_visibility_q_r <= internal_visibility_r;
      pk_map_r <= f_single(mode_r) ||
        (mode_r != `OMP_M_PER && !(emk_r && mode_r[0]));
      pe_map_r <= f_single(mode_r) ||
        !(eme_r && (mode_r[0] || mode_r == `OMP_M_PER));
    end
  end

  assign readdata = rdata_r;
  assign waitrequest = wait_r;
  assign ext_echo_o = echo_r;
  assign mode_o = mode_q_r;
  assign internal_visibility_o = internal_visibility_q_r;
  assign port_k_mapped_o = pk_map_r;
  assign port_e_mapped_o = pe_map_r;
  assign pull_a_o = pa_r;
  assign pull_b_o = pb_r;
  assign pull_e_o = pe_r;
  assign pull_k_o = pk_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_mode_wr;
    wr_mode;
  endsequence

  sequence s_held;
    $stable(mode_r) ##1 $stable(mode_r);
  endsequence

  bus_answer_a: assert property (
    idle_req |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not in one cycle");

  mode_delay_a: assert property (
    s_mode_wr ##0 mod_ok |=> $stable(mode_r) ##1 (mode_r == $past(mode_nxt, 2)))
    else $error("mode write not delayed by one cycle");

  absent_echo_a: assert property (
    idle_req && !in_map |=> ext_echo_o && readdata == 32'h0)
    else $error("absent register not echoed");

  lowbit_lock_a: assert property (
    ack_wr && mode_r[0] |=> s_held)
    else $error("mode changed while lowest bit set");

  periph_guard_a: assert property (
    s_mode_wr ##0 (!mode_r[2] && mod_w == `OMP_M_PER) |=> s_held)
    else $error("special peripheral mode reached by write");

  single_top_a: assert property (
    mode_r == `OMP_M_NSC |=> mode_r[2])
    else $error("top mode bit left normal single chip");

  secure_lock_a: assert property (
    s_mode_wr ##0 secure_r |=> s_held)
    else $error("mode written while secure");

  once_used_a: assert property (
    s_mode_wr ##0 (mode_r == `OMP_M_NSC && mod_once_r) |=> s_held)
    else $error("second write left normal single chip");

  eme_never_a: assert property (
    s_mode_wr ##0 !f_special(mode_r) |=> ##1 (eme_r == $past(eme_r, 2)))
    else $error("port E emulation written outside special");

  pull_input_a: assert property (
    1'h1 |=> pull_a_o == ($past(pull_r[0]) ? ~$past(dir_a) : 8'h0))
    else $error("port A pull not gated by direction");

  reset_pull_a: assert property (
    $past(rstn) |-> pull_e_o[6:5] == 2'h0)
    else $error("port E pins 6:5 pulled after reset");

  nsc_entry_a: assert property (
    s_mode_wr ##0 (!mode_r[2] && mod_ok && mod_w == `OMP_M_NSC) |=>
      ##1 (mode_r == `OMP_M_NSC && !mod_once_r))
    else $error("entry to normal single chip left no write");

  internal_visibility_once_a: assert property (
    s_mode_wr ##0 (!f_special(mode_r) && internal_visibility_once_r) |=> ##1 (internal_visibility_r == $past(internal_visibility_r, 2)))
    else $error("visibility bit written twice outside special");

  port_k_map_a: assert property (
    mode_r == `OMP_M_PER |=> !port_k_mapped_o)
    else $error("port K mapped in special peripheral mode");

  pull_k_a: assert property (
    1'h1 |=> pull_k_o == ($past(pull_r[3]) ? ~$past(dir_k) : 8'h0))
    else $error("port K pull not gated by enable and direction");

  pull_b_a: assert property (
    1'h1 |=> pull_b_o == ($past(pull_r[1]) ? ~$past(dir_b) : 8'h0))
    else $error("port B pull not gated by enable and direction");

  once_flag_a: assert property (
    s_mode_wr ##0 (mode_r == `OMP_M_NSC && mod_ok) |=> mod_once_r)
    else $error("write-once flag not set by accepted write");

endmodule // omp_ctrl
`default_nettype wire

// ===== verif/omp_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module omp_ctrl_bench;
  import omp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic secure_pin = 1'b0;
  logic [1:0] address = 2'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h1;
  logic [2:0] mode_strap = 3'h0;
  logic [7:0] dir_a = 8'h00;
  logic [7:0] dir_b = 8'h00;
  logic [7:0] dir_e = 8'h00;
  logic [7:0] dir_k = 8'h00;
  logic [31:0] readdata;
  logic waitrequest;
  logic [2:0] mode_o;
  logic internal_visibility_o;
  logic port_k_mapped_o;
  logic port_e_mapped_o;
  logic ext_echo_o;
  logic [7:0] pull_a_o;
  logic [7:0] pull_b_o;
  logic [7:0] pull_e_o;
  logic [7:0] pull_k_o;
  logic [31:0] rdat;
  logic echo;
  int n_mismatch = 0;
  int check_count = 0;

  omp_ctrl omp_ctrl_i (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .mode_strap(mode_strap), .secure_pin(secure_pin),
    .dir_a(dir_a), .dir_b(dir_b), .dir_e(dir_e), .dir_k(dir_k), .mode_o(mode_o),
    .internal_visibility_o(internal_visibility_o), .port_k_mapped_o(port_k_mapped_o),
    .port_e_mapped_o(port_e_mapped_o), .ext_echo_o(ext_echo_o), .pull_a_o(pull_a_o),
    .pull_b_o(pull_b_o), .pull_e_o(pull_e_o), .pull_k_o(pull_k_o)
  );

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic summarize();
    $display("Checks made: %0d, mismatches: %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask

  // Waits for the answer edge; the request stays up until waitrequest is sampled low.
  task automatic wait_answer();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      chk("bus answer waitrequest", {31'h0, waitrequest}, 32'h0);
      summarize();
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= 1'b1;
    wait_answer();
    write <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    wait_answer();
    rdat = readdata;
    echo = ext_echo_o;
    read <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rst(input logic [2:0] s, input logic sec);
    @(posedge clk);
    rstn <= 1'b0;
    mode_strap <= s;
    secure_pin <= sec;
    settle(16);
    chk("pull_e_o in reset", {24'h0, pull_e_o}, 32'h60);
    @(posedge clk);
    rstn <= 1'b1;
    settle(12);
  endtask

  initial begin
    rst(3'h0, 1'b0);
    rd(2'h0);
    chk("mode_config ssc", rdat, 32'h00);
    chk("echo mapped", {31'h0, echo}, 32'h0);
    wr(2'h1, 8'h93);
    rd(2'h1);
    chk("pull_enable_ctrl", rdat, 32'h93);
    settle(2);
    chk("pull_a_o", {24'h0, pull_a_o}, 32'hFF);
    chk("pull_b_o", {24'h0, pull_b_o}, 32'hFF);
    chk("pull_e_o", {24'h0, pull_e_o}, 32'h9F);
    chk("pull_k_o", {24'h0, pull_k_o}, 32'hFF);
    @(posedge clk);
    dir_a <= 8'hF0;
    dir_e <= 8'h81;
    settle(3);
    chk("pull_a_o outputs", {24'h0, pull_a_o}, 32'h0F);
    chk("pull_e_o outputs", {24'h0, pull_e_o}, 32'h1E);
    wr(2'h1, 8'h10);
    settle(2);
    chk("pull_a_o off", {24'h0, pull_a_o}, 32'h00);
    chk("pull_k_o off", {24'h0, pull_k_o}, 32'h00);
    chk("pull_e_o on", {24'h0, pull_e_o}, 32'h1E);
    @(posedge clk);
    byteenable <= 4'h0;
    wr(2'h1, 8'h83);
    byteenable <= 4'h1;
    rd(2'h1);
    chk("pull write lane off", rdat, 32'h10);
    wr(2'h0, 8'h4B);
    #1;
    chk("mode_o delayed", {29'h0, mode_o}, 32'h0);
    settle(3);
    chk("mode_o test", {29'h0, mode_o}, 32'h2);
    rd(2'h0);
    chk("mode_config test", rdat, 32'h4B);
    chk("internal_visibility out", {31'h0, internal_visibility_o}, 32'h1);
    chk("port_e mapped", {31'h0, port_e_mapped_o}, 32'h1);
    wr(2'h0, 8'hCB);
    settle(3);
    rd(2'h0);
    chk("mode_config no 110", rdat, 32'h4B);
    wr(2'h0, 8'h80);
    settle(3);
    rd(2'h0);
    chk("mode_config nsc", rdat, 32'h80);
    wr(2'h0, 8'h89);
    settle(3);
    rd(2'h0);
    chk("internal_visibility once eme never", rdat, 32'h88);
    wr(2'h0, 8'h80);
    wr(2'h0, 8'hC0);
    settle(3);
    rd(2'h0);
    chk("internal_visibility held no 110", rdat, 32'h88);
    wr(2'h0, 8'h22);
    settle(3);
    chk("mode_o nxn", {29'h0, mode_o}, 32'h5);
    chk("internal_visibility kept", {31'h0, internal_visibility_o}, 32'h1);
    chk("port_k mapped", {31'h0, port_k_mapped_o}, 32'h1);
    rd(2'h0);
    chk("absent mode read", rdat, 32'h0);
    chk("absent mode echo", {31'h0, echo}, 32'h1);
    rd(2'h1);
    chk("absent pull echo", {31'h0, echo}, 32'h1);
    wr(2'h0, 8'h60);
    settle(3);
    chk("mode_o locked", {29'h0, mode_o}, 32'h5);
    rst(3'h1, 1'b0);
    chk("mode_o emn", {29'h0, mode_o}, 32'h1);
    chk("port_k unmapped", {31'h0, port_k_mapped_o}, 32'h0);
    chk("port_e unmapped", {31'h0, port_e_mapped_o}, 32'h0);
    rst(3'h6, 1'b0);
    chk("mode_o per", {29'h0, mode_o}, 32'h6);
    rd(2'h0);
    chk("per mode echo", {31'h0, echo}, 32'h1);
    chk("per port_k", {31'h0, port_k_mapped_o}, 32'h0);
    rst(3'h0, 1'b1);
    wr(2'h0, 8'h40);
    settle(3);
    chk("mode_o secure", {29'h0, mode_o}, 32'h0);
    summarize();
  end
endmodule // omp_ctrl_bench
`default_nettype wire
